// ### verilog/crld_pkg.sv
// constants, types and register map of the command/response list engine
// assumes a 32-bit host memory port and an apb register port on one clock
package crld_pkg;

  // element layout: counts and indices in longwords, offsets in bytes
  localparam int          ELEM_WORDS     = 8;
  localparam int          W_CMD_LINK     = 0;
  localparam int          W_FUNC         = 3;
  localparam logic [31:0] WORD_BYTES     = 32'h0000_0004;
  localparam logic [31:0] RESP_LINK_OFS  = 32'h0000_0004;
  localparam logic [31:0] FUNC_OFS       = 32'h0000_000c;

  // function longword fields
  localparam int FN_CODE_HI  = 6;
  localparam int FN_CHAN_HI  = 15;
  localparam int FN_CHAN_LO  = 8;
  localparam int FN_KEEP_HI  = 23;
  localparam int FN_STAT_LO  = 24;

  // link fields
  localparam int LINK_VALID  = 31;
  localparam int CMD_VALID   = 0;
  localparam int ADDR_TOP_LO = 22;
  localparam int ADDR_LOW_HI = 3;

  localparam logic [7:0] CHAN_MAX = 8'h01;

  // command function codes
  localparam logic [6:0] CMD_DEV_PARAMS  = 7'h00;
  localparam logic [6:0] CMD_CHAN_PARAMS = 7'h01;
  localparam logic [6:0] CMD_INIT_CHAN   = 7'h10;
  localparam logic [6:0] CMD_UPD_CHAN    = 7'h11;
  localparam logic [6:0] CMD_RESET_CHAN  = 7'h13;
  localparam logic [6:0] CMD_TRANSMIT    = 7'h20;
  localparam logic [6:0] CMD_RECEIVE     = 7'h30;
  localparam logic [6:0] CMD_MODEM       = 7'h40;
  localparam logic [6:0] CMD_STAT_CHG    = 7'h50;
  localparam logic [6:0] CMD_MAINT       = 7'h7f;

  // completion status codes
  localparam logic [7:0] CST_UNRECOG  = 8'h03;
  localparam logic [7:0] CST_BAD_CHAN = 8'h04;

  // apb map (byte addresses)
  localparam logic [31:0] REG_CTRL      = 32'h0000_0000;
  localparam logic [31:0] REG_FLAG      = 32'h0000_0004;
  localparam logic [31:0] REG_MASK      = 32'h0000_0008;
  localparam logic [31:0] REG_BASE      = 32'h0000_000c;
  localparam logic [31:0] REG_CMD_LINK  = 32'h0000_0010;
  localparam logic [31:0] REG_RESP_TAIL = 32'h0000_0014;
  localparam logic [31:0] REG_LAST      = 32'h0000_0018;
  localparam logic [31:0] REG_STATE     = 32'h0000_001c;

  localparam int CTRL_EN         = 0;
  localparam int FLAG_COMMAND_AVAILABLE_FLAG  = 13;
  localparam int FLAG_RESPONSE_AVAILABLE_FLAG = 14;
  localparam int FLAG_ADDR_ERR   = 15;

  typedef enum logic [3:0] {
    OP_NONE, OP_DEV_PARAMS, OP_CHAN_PARAMS, OP_INIT_CHAN, OP_UPD_CHAN,
    OP_RESET_CHAN, OP_TRANSMIT, OP_RECEIVE, OP_MODEM, OP_STAT_CHG, OP_MAINT
  } crld_op_t;

  typedef enum logic [9:0] {
    ST_IDLE      = 10'h001,
    ST_FETCH     = 10'h002,
    ST_DECODE    = 10'h004,
    ST_WAIT_OP   = 10'h008,
    ST_WR_OWN    = 10'h010,
    ST_WR_FUNC   = 10'h020,
    ST_WR_TADDR  = 10'h040,
    ST_WR_TVALID = 10'h080,
    ST_NEXT      = 10'h100,
    ST_ABORT     = 10'h200
  } crld_state_t;

endpackage

// ### verilog/crld_core_if.sv
// carrier between the list engine and its decoder and link calculator
// assumes all three sit on one clock; signals are purely combinational
`timescale 1ns/1ps
`default_nettype none
interface crld_core_if;
  import crld_pkg::*;
  logic [31:0] func_word;
  crld_op_t    op;
  logic        code_ok;
  logic        chan_ok;
  logic [31:0] base;
  logic [31:0] rel;
  logic [31:0] tail;
  logic [31:0] elem_addr;
  logic        elem_ok;
  logic [31:0] tail_addr;
  logic        tail_ok;
  logic [31:0] link_field;

  modport core (output func_word, base, rel, tail,
                input  op, code_ok, chan_ok, elem_addr, elem_ok,
                       tail_addr, tail_ok, link_field);
  modport dec  (input func_word, output op, code_ok, chan_ok);
  modport lnk  (input base, rel, tail,
                output elem_addr, elem_ok, tail_addr, tail_ok, link_field);
endinterface
`default_nettype wire

// ### verilog/crld_decode.sv
// command code and channel decoder for the function longword
// assumes the function longword is stable while the engine decodes it
`timescale 1ns/1ps
`default_nettype none
module crld_decode (
  crld_core_if.dec dif
);
  import crld_pkg::*;

  always_comb begin
    dif.op      = OP_NONE;
    dif.code_ok = 1'b1;
    // bit 7 is left out of the case on purpose
    case (dif.func_word[FN_CODE_HI:0])
      CMD_DEV_PARAMS:  dif.op = OP_DEV_PARAMS;
      CMD_CHAN_PARAMS: dif.op = OP_CHAN_PARAMS;
      CMD_INIT_CHAN:   dif.op = OP_INIT_CHAN;
      CMD_UPD_CHAN:    dif.op = OP_UPD_CHAN;
      CMD_RESET_CHAN:  dif.op = OP_RESET_CHAN;
      CMD_TRANSMIT:    dif.op = OP_TRANSMIT;
      CMD_RECEIVE:     dif.op = OP_RECEIVE;
      CMD_MODEM:       dif.op = OP_MODEM;
      CMD_STAT_CHG:    dif.op = OP_STAT_CHG;
      CMD_MAINT:       dif.op = OP_MAINT;
      default:         dif.code_ok = 1'b0; // 12, 21, 31 land here
    endcase
    dif.chan_ok = dif.func_word[FN_CHAN_HI:FN_CHAN_LO] <= CHAN_MAX;
  end

endmodule // crld_decode
`default_nettype wire

// ### verilog/crld_link.sv
// relative-to-bus address arithmetic for command and response links
// assumes base and links are held steady by the engine's registers
`timescale 1ns/1ps
`default_nettype none
module crld_link (
  crld_core_if.lnk lif
);
  import crld_pkg::*;

  // sum plus alignment check, bit 32 set when the sum is a legal address
  function automatic logic [32:0] rel_sum(input logic [31:0] b,
                                          input logic [31:0] r);
    logic [31:0] s;
    s = b + r;
    rel_sum = {(s[31:ADDR_TOP_LO] == '0) && (s[ADDR_LOW_HI:0] == '0), s};
  endfunction

  logic [32:0] esum;
  logic [32:0] tsum;

  always_comb begin
    esum = rel_sum(lif.base, {lif.rel[31:1], 1'b0});
    // rotate left one, bit 0 forced low, then add base
    tsum = rel_sum(lif.base, {lif.tail[30:0], 1'b0});
    lif.elem_addr  = esum[31:0];
    lif.elem_ok    = esum[32];
    lif.tail_addr  = tsum[31:0];
    lif.tail_ok    = tsum[32];
    lif.link_field = {1'b0, lif.rel[31:1]};
  end

endmodule // crld_link
`default_nettype wire

// ### verilog/crld_top.sv
// command/response list engine: fetches elements from host memory,
// decodes them, hands them to channel logic and links the responses
// assumes a single-beat host memory port with a one-cycle ack pulse
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - response link bits 30:0 hold relative address 31:1
// - link valid bit 31 set after address write
// - link done before response available flag 14
// - last response element link written all zeros
// - next address: rotate left, clear bit0, add base
// - sum bits 31:22 and 3:0 zero
// - function longword split into four bytes
// - decode 00,01,10,11,13; 12 reserved
// - code 20 transmit; 21 reserved
// - code 30 receive; 31 reserved
// - code 40 modem, 50 status change
// - code 7f enters maintenance mode
// - channel byte only 00 or 01
// - element fetched as eight longwords, aligned
module crld_top #(
  parameter int ELEM_WORDS = crld_pkg::ELEM_WORDS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic             op_start,
  output crld_pkg::crld_op_t op_code,
  output logic      [7:0]  op_channel,
  input  wire logic        op_done,
  input  wire logic [7:0]  op_status,
  output logic             irq
);
  import crld_pkg::*;

  localparam int IW = $clog2(ELEM_WORDS);

  crld_core_if cif ();

  crld_decode u_decode (
    .dif (cif)
  );

  crld_link u_link (
    .lif (cif)
  );

  // register group
  logic        en_ff, nxt_en;
  logic        command_available_flag_ff, nxt_command_available_flag;
  logic        response_available_flag_ff, nxt_response_available_flag;
  logic        err_ff, nxt_err;
  logic        mask_resp_ff, nxt_mask_resp;
  logic        mask_err_ff, nxt_mask_err;
  logic [31:0] base_ff, nxt_base;
  logic [31:0] prdata_ff, nxt_prdata;

  // engine group
  crld_state_t state_ff, nxt_state;
  logic [31:0] elem_ff [ELEM_WORDS];
  logic [31:0] nxt_elem [ELEM_WORDS];
  logic [IW-1:0] idx_ff, nxt_idx;
  logic [31:0] cmd_link_ff, nxt_cmd_link;
  logic [31:0] tail_ff, nxt_tail;
  logic [31:0] last_ff, nxt_last;
  logic [7:0]  status_ff, nxt_status;
  logic        mem_req_ff, nxt_mem_req;
  logic        mem_we_ff, nxt_mem_we;
  logic [31:0] mem_addr_ff, nxt_mem_addr;
  logic [31:0] mem_wdata_ff, nxt_mem_wdata;
  logic        op_start_ff, nxt_op_start;
  crld_op_t    op_code_ff, nxt_op_code;
  logic [7:0]  op_chan_ff, nxt_op_chan;

  // events from the engine to the flag register
  logic ev_resp;
  logic ev_err;
  logic ev_list_end;

  // apb decode
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic [31:0] rd_mux;

  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_mux = '0;
    if (paddr == REG_CTRL) begin
      rd_mux[CTRL_EN] = en_ff;
    end else if (paddr == REG_FLAG) begin
      rd_mux[FLAG_COMMAND_AVAILABLE_FLAG]  = command_available_flag_ff;
      rd_mux[FLAG_RESPONSE_AVAILABLE_FLAG] = response_available_flag_ff;
      rd_mux[FLAG_ADDR_ERR]   = err_ff;
    end else if (paddr == REG_MASK) begin
      rd_mux[FLAG_RESPONSE_AVAILABLE_FLAG] = mask_resp_ff;
      rd_mux[FLAG_ADDR_ERR]   = mask_err_ff;
    end else if (paddr == REG_BASE) begin
      rd_mux = base_ff;
    end else if (paddr == REG_CMD_LINK) begin
      rd_mux = cmd_link_ff;
    end else if (paddr == REG_RESP_TAIL) begin
      rd_mux = tail_ff;
    end else if (paddr == REG_LAST) begin
      rd_mux = last_ff;
    end else if (paddr == REG_STATE) begin
      rd_mux[9:0] = state_ff;
    end else begin
      mapped = 1'b0;
    end
  end

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_ff;

  always_comb begin
    nxt_en         = en_ff;
    nxt_mask_resp  = mask_resp_ff;
    nxt_mask_err   = mask_err_ff;
    nxt_base       = base_ff;
    nxt_prdata     = rd_setup ? rd_mux : prdata_ff;
    nxt_command_available_flag  = command_available_flag_ff;
    nxt_response_available_flag = response_available_flag_ff;
    nxt_err        = err_ff;
    if (wr_en && paddr == REG_CTRL) begin
      nxt_en = pwdata[CTRL_EN];
    end else if (wr_en && paddr == REG_MASK) begin
      nxt_mask_resp = pwdata[FLAG_RESPONSE_AVAILABLE_FLAG];
      nxt_mask_err  = pwdata[FLAG_ADDR_ERR];
    end else if (wr_en && paddr == REG_BASE) begin
      nxt_base = {pwdata[31:1], 1'b0};
    end
    if (wr_en && paddr == REG_FLAG) begin
      if (pwdata[FLAG_RESPONSE_AVAILABLE_FLAG]) nxt_response_available_flag = 1'b0;
      if (pwdata[FLAG_ADDR_ERR])   nxt_err = 1'b0;
    end
    if (ev_list_end) nxt_command_available_flag = 1'b0;
    // software kick wins over the engine's end-of-list clear
    if (wr_en && paddr == REG_FLAG && pwdata[FLAG_COMMAND_AVAILABLE_FLAG]) begin
      nxt_command_available_flag = 1'b1;
    end
    // hardware set wins over a same-cycle write-one clear
    if (ev_resp) nxt_response_available_flag = 1'b1;
    if (ev_err)  nxt_err = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff         <= 1'b0;
      mask_resp_ff  <= 1'b0;
      mask_err_ff   <= 1'b0;
      base_ff       <= '0;
      prdata_ff     <= '0;
      command_available_flag_ff  <= 1'b0;
      response_available_flag_ff <= 1'b0;
      err_ff        <= 1'b0;
    end else begin
      en_ff         <= nxt_en;
      mask_resp_ff  <= nxt_mask_resp;
      mask_err_ff   <= nxt_mask_err;
      base_ff       <= nxt_base;
      prdata_ff     <= nxt_prdata;
      command_available_flag_ff  <= nxt_command_available_flag;
      response_available_flag_ff <= nxt_response_available_flag;
      err_ff        <= nxt_err;
    end
  end

  assign irq = (response_available_flag_ff && mask_resp_ff) || (err_ff && mask_err_ff);

  // engine
  assign cif.func_word = elem_ff[W_FUNC];
  assign cif.base      = base_ff;
  assign cif.rel       = cmd_link_ff;
  assign cif.tail      = tail_ff;

  always_comb begin
    nxt_state     = state_ff;
    nxt_elem      = elem_ff;
    nxt_idx       = idx_ff;
    nxt_cmd_link  = cmd_link_ff;
    nxt_tail      = tail_ff;
    nxt_last      = last_ff;
    nxt_status    = status_ff;
    nxt_mem_req   = mem_req_ff;
    nxt_mem_we    = mem_we_ff;
    nxt_mem_addr  = mem_addr_ff;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_op_start  = 1'b0;
    nxt_op_code   = op_code_ff;
    nxt_op_chan   = op_chan_ff;
    ev_resp       = 1'b0;
    ev_err        = 1'b0;
    ev_list_end   = 1'b0;
    // link registers are only software-writable while the engine rests
    if (state_ff == ST_IDLE && wr_en && paddr == REG_CMD_LINK) begin
      nxt_cmd_link = pwdata;
    end
    if (state_ff == ST_IDLE && wr_en && paddr == REG_RESP_TAIL) begin
      nxt_tail = pwdata;
    end
    case (state_ff)
      ST_IDLE: begin
        if (en_ff && command_available_flag_ff) begin
          if (cif.elem_ok) begin
            nxt_state    = ST_FETCH;
            nxt_idx      = '0;
            nxt_mem_req  = 1'b1;
            nxt_mem_we   = 1'b0;
            nxt_mem_addr = cif.elem_addr;
          end else begin
            nxt_state = ST_ABORT;
          end
        end
      end
      ST_FETCH: begin
        if (mem_ack) begin
          nxt_elem[idx_ff] = mem_rdata;
          if (idx_ff == IW'(ELEM_WORDS - 1)) begin
            nxt_mem_req = 1'b0;
            nxt_state   = ST_DECODE;
          end else begin
            nxt_idx      = idx_ff + 1'b1;
            nxt_mem_addr = mem_addr_ff + WORD_BYTES;
          end
        end
      end
      ST_DECODE: begin
        nxt_op_chan = cif.func_word[FN_CHAN_HI:FN_CHAN_LO];
        if (!cif.code_ok) begin
          nxt_status = CST_UNRECOG; // no channel work started
          nxt_state  = ST_WR_OWN;
        end else if (!cif.chan_ok) begin
          nxt_status = CST_BAD_CHAN;
          nxt_state  = ST_WR_OWN;
        end else begin
          nxt_op_start = 1'b1;
          nxt_op_code  = cif.op;
          nxt_state    = ST_WAIT_OP;
        end
        if (nxt_state == ST_WR_OWN) begin
          nxt_mem_req   = 1'b1;
          nxt_mem_we    = 1'b1;
          nxt_mem_addr  = cif.elem_addr + RESP_LINK_OFS;
          nxt_mem_wdata = '0;
        end
      end
      ST_WAIT_OP: begin
        if (op_done) begin
          nxt_status    = op_status;
          nxt_state     = ST_WR_OWN;
          nxt_mem_req   = 1'b1;
          nxt_mem_we    = 1'b1;
          nxt_mem_addr  = cif.elem_addr + RESP_LINK_OFS;
          nxt_mem_wdata = '0; // new element is the last response
        end
      end
      ST_WR_OWN: begin
        if (mem_ack) begin
          nxt_state     = ST_WR_FUNC;
          nxt_mem_addr  = cif.elem_addr + FUNC_OFS;
          nxt_mem_wdata = {status_ff, cif.func_word[FN_KEEP_HI:0]};
        end
      end
      ST_WR_FUNC: begin
        if (mem_ack) begin
          nxt_last = {status_ff, cif.func_word[FN_KEEP_HI:0]};
          if (!tail_ff[LINK_VALID]) begin
            nxt_mem_req = 1'b0;
            nxt_state   = ST_NEXT;
          end else if (cif.tail_ok) begin
            nxt_state     = ST_WR_TADDR;
            nxt_mem_addr  = cif.tail_addr + RESP_LINK_OFS;
            nxt_mem_wdata = cif.link_field;
          end else begin
            nxt_mem_req = 1'b0;
            nxt_state   = ST_ABORT;
          end
        end
      end
      ST_WR_TADDR: begin
        if (mem_ack) begin
          nxt_state = ST_WR_TVALID;
          // second write of the same word only adds the valid mark
          nxt_mem_wdata = cif.link_field;
          nxt_mem_wdata[LINK_VALID] = 1'b1;
        end
      end
      ST_WR_TVALID: begin
        if (mem_ack) begin
          nxt_mem_req = 1'b0;
          nxt_state   = ST_NEXT;
        end
      end
      ST_NEXT: begin
        // flag only after every link write has been acknowledged
        ev_resp  = 1'b1;
        nxt_tail = cif.link_field;
        nxt_tail[LINK_VALID] = 1'b1;
        if (elem_ff[W_CMD_LINK][CMD_VALID]) begin
          nxt_cmd_link = {elem_ff[W_CMD_LINK][31:1], 1'b0};
        end else begin
          // link bit 0 clear: list ends, wait for the next kick on the same element
          ev_list_end = 1'b1;
        end
        nxt_state = ST_IDLE;
      end
      ST_ABORT: begin
        ev_err      = 1'b1;
        ev_list_end = 1'b1;
        nxt_state   = ST_IDLE;
      end
      default: begin
        nxt_state   = ST_IDLE;
        nxt_mem_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= ST_IDLE;
      for (int i = 0; i < ELEM_WORDS; i++) begin
        elem_ff[i] <= '0;
      end
      idx_ff       <= '0;
      cmd_link_ff  <= '0;
      tail_ff      <= '0;
      last_ff      <= '0;
      status_ff    <= '0;
      mem_req_ff   <= 1'b0;
      mem_we_ff    <= 1'b0;
      mem_addr_ff  <= '0;
      mem_wdata_ff <= '0;
      op_start_ff  <= 1'b0;
      op_code_ff   <= OP_NONE;
      op_chan_ff   <= '0;
    end else begin
      state_ff     <= nxt_state;
      elem_ff      <= nxt_elem;
      idx_ff       <= nxt_idx;
      cmd_link_ff  <= nxt_cmd_link;
      tail_ff      <= nxt_tail;
      last_ff      <= nxt_last;
      status_ff    <= nxt_status;
      mem_req_ff   <= nxt_mem_req;
      mem_we_ff    <= nxt_mem_we;
      mem_addr_ff  <= nxt_mem_addr;
      mem_wdata_ff <= nxt_mem_wdata;
      op_start_ff  <= nxt_op_start;
      op_code_ff   <= nxt_op_code;
      op_chan_ff   <= nxt_op_chan;
    end
  end

  assign mem_req    = mem_req_ff;
  assign mem_we     = mem_we_ff;
  assign mem_addr   = mem_addr_ff;
  assign mem_wdata  = mem_wdata_ff;
  assign op_start   = op_start_ff;
  assign op_code    = op_code_ff;
  assign op_channel = op_chan_ff;

endmodule // crld_top
`default_nettype wire

// ### test/crld_properties.sv
// port-level checker for crld_top, attached by bind
// assumes one clock, presetn active low
`timescale 1ns/1ps
`default_nettype none
module crld_properties #(
  parameter int ELEM_WORDS = crld_pkg::ELEM_WORDS
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic        [31:0] paddr,
  input wire logic               pslverr,
  input wire logic               mem_req,
  input wire logic               mem_we,
  input wire logic        [31:0] mem_addr,
  input wire logic        [31:0] mem_wdata,
  input wire logic               mem_ack,
  input wire logic               op_start,
  input wire crld_pkg::crld_op_t op_code,
  input wire logic        [7:0]  op_channel
);
  import crld_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr_ack = mem_req & mem_we & mem_ack;
  wire rd_ack = mem_req & ~mem_we & mem_ack;
  logic [31:0] wa_ff, wd_ff, ra_ff;
  logic [3:0]  rc_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wa_ff <= '0;
      wd_ff <= '0;
      ra_ff <= '0;
      rc_ff <= '0;
    end else begin
      if (wr_ack) wa_ff <= mem_addr;
      if (wr_ack) wd_ff <= mem_wdata;
      if (rd_ack) ra_ff <= mem_addr;
      if (wr_ack || op_start) rc_ff <= '0;
      else if (rd_ack) rc_ff <= rc_ff + 4'h1;
    end
  end
  a_unmap_err: assert property (psel && penable && paddr > REG_STATE
    |-> pslverr) else $error("unmapped access without pslverr");
  a_start_pulse: assert property (op_start |=> !op_start)
    else $error("op_start longer than one cycle");
  a_start_legal: assert property (
    op_start |-> op_code != OP_NONE && op_channel <= CHAN_MAX)
    else $error("operation started for a bad element");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req &&
    $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  a_addr_range: assert property (
    mem_req |-> mem_addr[31:22] == 10'h000 && mem_addr[1:0] == 2'h0)
    else $error("memory address out of range");
  // over-strict if a status byte above 7f is passed back
  a_valid_late: assert property (wr_ack && mem_wdata[31] |->
    wa_ff == mem_addr && wd_ff == {1'b0, mem_wdata[30:0]})
    else $error("valid bit written without prior address");
  a_fetch_count: assert property (
    op_start |-> rc_ff == ELEM_WORDS)
    else $error("operation started before full fetch");
  a_fetch_step: assert property (
    rd_ack && rc_ff != 4'h0 |-> mem_addr == ra_ff + 32'h4)
    else $error("fetch beats not consecutive");
  a_wait_quiet: assert property (op_start |=> !mem_req)
    else $error("memory access while operation runs");
endmodule // crld_properties
bind crld_top crld_properties #(.ELEM_WORDS(ELEM_WORDS)) u_prop (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
  .op_start(op_start), .op_code(op_code), .op_channel(op_channel));
`default_nettype wire

// ### test/crld_host_mem.sv
// host memory model on the engine's single-beat port
// assumes a 4 KiB window; lag adds wait cycles before each ack
`timescale 1ns/1ps
`default_nettype none
module crld_host_mem (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  lag,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata
);
  logic [31:0] m [0:1023];
  logic [1:0]  wt_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= '0;
      wt_ff <= '0;
    end else if (mem_req && !mem_ack && wt_ff >= lag) begin
      mem_ack <= 1'b1;
      wt_ff <= '0;
      // only engine writes alter memory: host words stay put
      if (mem_we) m[mem_addr[11:2]] <= mem_wdata;
      mem_rdata <= mem_we ? ~mem_rdata : m[mem_addr[11:2]];
    end else begin
      mem_ack <= 1'b0;
      // idle bus never repeats the last word
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) wt_ff <= wt_ff + 2'h1;
    end
  end
endmodule // crld_host_mem
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for crld_top with host memory model
// assumes apb at 125 MHz and a bench-side channel responder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import crld_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        mem_req, mem_we, mem_ack, op_start, irq, sl;
  logic        op_done = 1'b0;
  logic [1:0]  lag, pend;
  logic [7:0]  op_channel, st_next, last_ch;
  logic [7:0]  op_status = 8'h00;
  logic [31:0] paddr, pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd;
  crld_op_t    op_code, last_op;
  int          errors = 0, checks_done = 0, starts = 0;
  crld_top #(.ELEM_WORDS(8)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .op_start(op_start), .op_code(op_code), .op_channel(op_channel),
    .op_done(op_done), .op_status(op_status), .irq(irq));
  crld_host_mem hm (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .lag(lag), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // channel side answers three cycles after each start
  always @(posedge pclk) begin
    pend <= {pend[0], op_start === 1'b1};
    op_done <= pend[1];
    if (op_start === 1'b1) begin
      starts <= starts + 1;
      last_op <= op_code;
      last_ch <= op_channel;
      op_status <= st_next;
    end
  end
  task automatic tally_and_finish();
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run(input logic [31:0] rel, fn, input logic [7:0] st,
                     input crld_op_t op);
    int s0, k, b;
    b = rel[11:2];
    hm.m[b] = 32'h0;
    hm.m[b+1] = 32'hdead_beef;
    hm.m[b+2] = 32'h5a5a_a5a5;
    hm.m[b+3] = fn;
    s0 = starts;
    st_next = st;
    apb(1'b1, REG_CMD_LINK, rel);
    apb(1'b1, REG_FLAG, 32'h0000_2000);
    k = 0;
    rd = 32'h0000_2000;
    while (rd[13] === 1'b1 && k < 100) begin
      apb(1'b0, REG_FLAG, 32'h0);
      k++;
    end
    chk("starts", (op == OP_NONE) ? s0 : s0 + 1, starts);
    if (op != OP_NONE) chk("op_code", op, last_op);
    if (op != OP_NONE) chk("channel", fn[15:8], last_ch);
    chk("resp link", 32'h0, hm.m[b+1]);
    chk("func word", {st, fn[23:0]}, hm.m[b+3]);
    chk("host word", 32'h5a5a_a5a5, hm.m[b+2]);
  endtask
  task automatic t_reset();
    apb(1'b0, REG_FLAG, 32'h0);
    chk("flag reset", 32'h0, rd);
    chk("irq reset", 1'b0, irq);
    apb(1'b0, 32'h0000_0040, 32'h0);
    chk("unmapped err", 1'b1, sl);
    chk("unmapped data", 32'h0, rd);
  endtask
  task automatic t_decode();
    logic [7:0] c [14] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h13, 8'ha0,
      8'h30, 8'h40, 8'h50, 8'hff, 8'h12, 8'h21, 8'h31, 8'h02};
    crld_op_t o [14] = '{OP_DEV_PARAMS, OP_CHAN_PARAMS, OP_INIT_CHAN,
      OP_UPD_CHAN, OP_RESET_CHAN, OP_TRANSMIT, OP_RECEIVE, OP_MODEM,
      OP_STAT_CHG, OP_MAINT, OP_NONE, OP_NONE, OP_NONE, OP_NONE};
    logic [7:0] st;
    for (int i = 0; i < 14; i++) begin
      lag <= 2'(i % 3);
      st = (o[i] == OP_NONE) ? CST_UNRECOG : 8'(i + 8'h20);
      // fresh response list, else the last run links into this element
      apb(1'b1, REG_RESP_TAIL, 32'h0);
      // bit 7 set on a0 and ff must not change the decode
      run(32'h100, {16'h0055, 8'(i % 2), c[i]}, st, o[i]);
    end
  endtask
  task automatic t_chan();
    apb(1'b1, REG_RESP_TAIL, 32'h0);
    run(32'h100, 32'h0000_0220, CST_BAD_CHAN, OP_NONE);
  endtask
  task automatic t_link();
    hm.m[32'h81] = 32'h0;
    apb(1'b1, REG_FLAG, 32'h0000_4000);
    apb(1'b1, REG_MASK, 32'h0000_4000);
    chk("irq clear", 1'b0, irq);
    apb(1'b1, REG_RESP_TAIL, 32'h8000_0100);
    run(32'h100, 32'h0000_0140, 8'h00, OP_MODEM);
    chk("tail link", 32'h8000_0080, hm.m[32'h81]);
    apb(1'b0, REG_RESP_TAIL, 32'h0);
    chk("tail reg", 32'h8000_0080, rd);
    chk("irq set", 1'b1, irq);
    apb(1'b1, REG_FLAG, 32'h0000_4000);
    chk("irq w1c", 1'b0, irq);
  endtask
  task automatic t_align();
    int s0;
    s0 = starts;
    apb(1'b1, REG_MASK, 32'h0000_8000);
    apb(1'b1, REG_CMD_LINK, 32'h0000_0108);
    apb(1'b1, REG_FLAG, 32'h0000_2000);
    repeat (4) apb(1'b0, REG_FLAG, 32'h0);
    chk("abort flags", 32'h0000_8000, rd & 32'h0000_a000);
    chk("abort irq", 1'b1, irq);
    chk("abort starts", s0, starts);
    apb(1'b1, REG_FLAG, 32'h0000_8000);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    lag = 2'h0;
    pend = 2'h0;
    st_next = 8'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    // base offset is one whole 4 KiB model window, so each element still sits at rel[11:2]
    apb(1'b1, REG_BASE, 32'h0000_1000);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    t_decode();
    t_chan();
    t_link();
    t_align();
    tally_and_finish();
  end
  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
